// ==== shared/psc_pkg.sv ====
// Constants and types shared by the port statistics counter block.
// Assumes a single 40 MHz core clock and a classic Wishbone slave port.
package psc_pkg;

   // ****************************************
   // Geometry
   // ****************************************
   localparam int NPORT = 3;
   localparam int NCNT = 32;
   localparam int NENT = 96;
   localparam int NDROP = 6;
   localparam int CNT_W = 30;
   localparam int DROP_W = 16;
   localparam int OVF_BIT = 31;
   localparam int VALID_BIT = 30;

   // ****************************************
   // Indirect space
   // ****************************************
   localparam logic [8:0] PORT1_BASE = 9'h000;
   localparam logic [8:0] PORT2_BASE = 9'h020;
   localparam logic [8:0] PORT3_BASE = 9'h040;
   localparam logic [8:0] DROP_TX_BASE = 9'h100;
   localparam logic [8:0] DROP_RX_BASE = 9'h103;
   localparam logic [8:0] DROP_LAST = 9'h105;
   localparam logic [7:0] SEL_PORT_CNT = 8'h1c;
   localparam logic [7:0] SEL_DROP_CNT = 8'h1d;

   // ****************************************
   // Per-port counter offsets
   // ****************************************
   localparam int OFF_RX_LO_OCT = 'h00;
   localparam int OFF_RX_HI_OCT = 'h01;
   localparam int OFF_RX_SHORT = 'h02;
   localparam int OFF_RX_BROKEN = 'h03;
   localparam int OFF_RX_LONG_GOOD = 'h04;
   localparam int OFF_RX_LONG_BAD = 'h05;
   localparam int OFF_RX_BAD_SYM = 'h06;
   localparam int OFF_RX_CRC_FAIL = 'h07;
   localparam int OFF_RX_MISALIGN = 'h08;
   localparam int OFF_RX_MAC_CTRL = 'h09;
   localparam int OFF_RX_PAUSE = 'h0a;
   localparam int OFF_RX_BCAST = 'h0b;
   localparam int OFF_RX_MCAST = 'h0c;
   localparam int OFF_RX_UCAST = 'h0d;
   localparam int OFF_RX_LEN_MIN = 'h0e;
   localparam int OFF_TX_LO_OCT = 'h14;
   localparam int OFF_TX_HI_OCT = 'h15;
   localparam int OFF_TX_LATE_COLL = 'h16;
   localparam int OFF_TX_PAUSE = 'h17;
   localparam int OFF_TX_BCAST = 'h18;
   localparam int OFF_TX_MCAST = 'h19;
   localparam int OFF_TX_UCAST = 'h1a;
   localparam int OFF_TX_DELAYED = 'h1b;
   localparam int OFF_TX_ALL_COLL = 'h1c;
   localparam int OFF_TX_TOO_MANY = 'h1d;
   localparam int OFF_TX_ONE_COLL = 'h1e;
   localparam int OFF_TX_MANY_COLL = 'h1f;

   // ****************************************
   // Frame sizes in octets
   // ****************************************
   localparam int MIN_FRAME = 64;
   localparam int MAX_STD = 1522;
   localparam int MAX_LONG = 1536;
   localparam int BKT1_TOP = 127;
   localparam int BKT2_TOP = 255;
   localparam int BKT3_TOP = 511;
   localparam int BKT4_TOP = 1023;

   // ****************************************
   // Wishbone register map
   // ****************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_OFFSET = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam int CTRL_MAX1536_BIT = 8;
   localparam int OFFSET_MSB_BIT = 8;

   typedef enum logic {
      PSC_ST_FETCH,
      PSC_ST_UPDATE
   } psc_phase_e;

endpackage : psc_pkg

// ==== src/psc_mem.sv ====
// Counter storage: one word per per-port counter, registered read data.
// Assumes at most one write and one read per cycle, at different entries.
`timescale 1ns/1ps
module psc_mem #(
   parameter int DEPTH = 96,
   parameter int WIDTH = 32,
   parameter int AW = 7
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic [WIDTH-1:0] rd_data_o,
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i
);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] word;
      logic [WIDTH-1:0] rdata;
   } psc_mem_s;

   psc_mem_s s;
   psc_mem_s next_s;

   if (DEPTH > (1 << AW)) begin : g_chk
      $error("psc_mem: address too narrow for depth");
   end

   // Reset clears every word so counts start at zero
   always_comb begin
      next_s = s;
      next_s.rdata = s.word[rd_addr_i];
      if (wr_en_i) begin
         next_s.word[wr_addr_i] = wr_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rd_data_o = s.rdata;

endmodule : psc_mem

// ==== src/psc_top.sv ====
// Port statistics counters for a three-port switch with a Wishbone slave.
// Assumes MAC event inputs are one-cycle pulses synchronous to clk_i.
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps

// Functional notes
// - 32 per-port counters plus shared drop counters
// - Bit 31 flags overflow, resets to zero
// - Bit 30 set only when count valid
// - Bits 29:0 count, zero after reset
// - Port bases 0x00, 0x20, 0x40
// - 0x0/0x1 rx octets low/high priority
// - 0x2 short good, 0x3 short bad
// - 0x4 oversize good, limit 1536 or 1522
// - 0x5 oversize with errors
// - 0x6 legal size with bad symbol
// - 0x7 bad checksum, 0x8 misaligned
// - 0x9 MAC control type frames
// - 0xA qualified received pause frames
// - 0xB-0xD rx broadcast, multicast, unicast
// - 0xE-0x13 rx length buckets
// - 0x14/0x15 tx good octets by priority
// - 0x16 late transmit collisions
// - 0x17 tx pause, 0x18-0x1A tx casts
// - 0x1B deferred, 0x1C all collisions
// - 0x1D excessive, 0x1E one, 0x1F many
// - Drop counters 16 bits, reserved bits zero
// - Drops at 0x100-0x102 tx, 0x103-0x105 rx
// - Per-port counter cleared when read
// - Drop counters never cleared, no flags
module psc_top #(
   parameter int LEN_W = 11,
   parameter int PEND_W = 20
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [2:0] rx_done_i,
   input wire logic [2:0][LEN_W-1:0] rx_len_i,
   input wire logic [2:0] rx_crc_ok_i,
   input wire logic [2:0] rx_dribble_i,
   input wire logic [2:0] rx_sym_err_i,
   input wire logic [2:0] rx_hi_prio_i,
   input wire logic [2:0] rx_bcast_i,
   input wire logic [2:0] rx_mcast_i,
   input wire logic [2:0] rx_ctrl_type_i,
   input wire logic [2:0] rx_pause_match_i,
   input wire logic [2:0] tx_done_i,
   input wire logic [2:0][LEN_W-1:0] tx_len_i,
   input wire logic [2:0] tx_ok_i,
   input wire logic [2:0] tx_hi_prio_i,
   input wire logic [2:0] tx_pause_i,
   input wire logic [2:0] tx_bcast_i,
   input wire logic [2:0] tx_mcast_i,
   input wire logic [2:0] tx_defer_i,
   input wire logic [2:0][4:0] tx_coll_cnt_i,
   input wire logic [2:0] tx_excess_i,
   input wire logic [2:0] tx_late_coll_i,
   input wire logic [2:0] tx_drop_i,
   input wire logic [2:0] rx_drop_i
);

   localparam int NENT = psc_pkg::NENT;

   // ****************************************
   // Elaboration checks
   // ****************************************
   // Pending must absorb a full sweep of worst-case octets without wrapping
   if (LEN_W < 11 || PEND_W < 19 || PEND_W > psc_pkg::CNT_W - 1) begin : g_chk
      $error("psc_top: LEN_W or PEND_W out of range");
   end

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic [7:0] sel;
      logic max1536;
      logic [8:0] off;
      logic [31:0] data;
      logic req;
      logic [6:0] req_idx;
      psc_pkg::psc_phase_e phase;
      logic svc;
      logic [6:0] cur;
      logic [6:0] sweep;
      logic [NENT-1:0][PEND_W-1:0] pend;
      logic [psc_pkg::NDROP-1:0][psc_pkg::DROP_W-1:0] drop;
   } psc_state_s;

   psc_state_s s;
   psc_state_s next_s;

   logic [NENT-1:0][LEN_W-1:0] inc;
   logic [6:0] mem_raddr;
   logic [31:0] mem_rdata;
   logic mem_we;
   logic [31:0] mem_wdata;
   logic [30:0] sum;
   logic ovf;

   // ****************************************
   // Frame classification per port
   // ****************************************
   for (genvar p = 0; p < psc_pkg::NPORT; p++) begin : g_port
      logic [31:0] rl;
      logic [31:0] lim;
      logic legal;
      logic bad;
      logic good;
      logic [LEN_W-1:0] one;
      assign rl = 32'(rx_len_i[p]);
      assign lim = s.max1536 ? 32'(psc_pkg::MAX_LONG) : 32'(psc_pkg::MAX_STD);
      assign legal = rl >= 32'(psc_pkg::MIN_FRAME) && rl <= lim;
      assign bad = !rx_crc_ok_i[p] || rx_dribble_i[p] || rx_sym_err_i[p];
      assign good = legal && !bad;
      assign one = LEN_W'(1);
      always_comb begin
         inc[p*psc_pkg::NCNT +: psc_pkg::NCNT] = '0;
         if (rx_done_i[p]) begin
            // Ports share layout; entry index equals indirect offset
            // Constant indices keep each port's writes apart from the other ports
            if (rx_hi_prio_i[p]) begin
               inc[p*32 + psc_pkg::OFF_RX_HI_OCT] = rx_len_i[p];
            end else begin
               inc[p*32 + psc_pkg::OFF_RX_LO_OCT] = rx_len_i[p];
            end
            if (rl < 32'(psc_pkg::MIN_FRAME)) begin
               inc[p*32 + psc_pkg::OFF_RX_SHORT] = bad ? '0 : one;
               inc[p*32 + psc_pkg::OFF_RX_BROKEN] = bad ? one : '0;
            end
            if (rl > lim) begin
               inc[p*32 + psc_pkg::OFF_RX_LONG_GOOD] = bad ? '0 : one;
               inc[p*32 + psc_pkg::OFF_RX_LONG_BAD] = bad ? one : '0;
            end
            if (legal) begin
               inc[p*32 + psc_pkg::OFF_RX_BAD_SYM] = rx_sym_err_i[p] ? one : '0;
               if (!rx_crc_ok_i[p] && rx_dribble_i[p]) begin
                  inc[p*32 + psc_pkg::OFF_RX_MISALIGN] = one;
               end else if (!rx_crc_ok_i[p]) begin
                  inc[p*32 + psc_pkg::OFF_RX_CRC_FAIL] = one;
               end
            end
            inc[p*32 + psc_pkg::OFF_RX_MAC_CTRL] = (rx_ctrl_type_i[p] && rx_crc_ok_i[p]) ? one : '0;
            inc[p*32 + psc_pkg::OFF_RX_PAUSE] = (rx_ctrl_type_i[p] && rx_pause_match_i[p] && good) ? one : '0;
            if (good) begin
               inc[p*32 + psc_pkg::OFF_RX_BCAST] = rx_bcast_i[p] ? one : '0;
               inc[p*32 + psc_pkg::OFF_RX_MCAST] = (rx_mcast_i[p] && !rx_bcast_i[p] && !rx_ctrl_type_i[p]) ? one : '0;
               inc[p*32 + psc_pkg::OFF_RX_UCAST] = (!rx_mcast_i[p] && !rx_bcast_i[p]) ? one : '0;
            end
            if (legal) begin
               // Buckets count bad frames too
               if (rl == 32'(psc_pkg::MIN_FRAME)) begin
                  inc[p*32 + psc_pkg::OFF_RX_LEN_MIN] = one;
               end else if (rl <= 32'(psc_pkg::BKT1_TOP)) begin
                  inc[p*32 + psc_pkg::OFF_RX_LEN_MIN + 1] = one;
               end else if (rl <= 32'(psc_pkg::BKT2_TOP)) begin
                  inc[p*32 + psc_pkg::OFF_RX_LEN_MIN + 2] = one;
               end else if (rl <= 32'(psc_pkg::BKT3_TOP)) begin
                  inc[p*32 + psc_pkg::OFF_RX_LEN_MIN + 3] = one;
               end else if (rl <= 32'(psc_pkg::BKT4_TOP)) begin
                  inc[p*32 + psc_pkg::OFF_RX_LEN_MIN + 4] = one;
               end else begin
                  inc[p*32 + psc_pkg::OFF_RX_LEN_MIN + 5] = one;
               end
            end
         end
         inc[p*32 + psc_pkg::OFF_TX_LATE_COLL] = tx_late_coll_i[p] ? one : '0;
         if (tx_done_i[p]) begin
            inc[p*32 + psc_pkg::OFF_TX_DELAYED] = tx_defer_i[p] ? one : '0;
            inc[p*32 + psc_pkg::OFF_TX_ALL_COLL] = LEN_W'(tx_coll_cnt_i[p]);
            inc[p*32 + psc_pkg::OFF_TX_TOO_MANY] = tx_excess_i[p] ? one : '0;
            if (tx_ok_i[p]) begin
               if (tx_hi_prio_i[p]) begin
                  inc[p*32 + psc_pkg::OFF_TX_HI_OCT] = tx_len_i[p];
               end else begin
                  inc[p*32 + psc_pkg::OFF_TX_LO_OCT] = tx_len_i[p];
               end
               inc[p*32 + psc_pkg::OFF_TX_PAUSE] = tx_pause_i[p] ? one : '0;
               inc[p*32 + psc_pkg::OFF_TX_BCAST] = tx_bcast_i[p] ? one : '0;
               inc[p*32 + psc_pkg::OFF_TX_MCAST] = (tx_mcast_i[p] && !tx_bcast_i[p]) ? one : '0;
               inc[p*32 + psc_pkg::OFF_TX_UCAST] = (!tx_mcast_i[p] && !tx_bcast_i[p]) ? one : '0;
               inc[p*32 + psc_pkg::OFF_TX_ONE_COLL] = (tx_coll_cnt_i[p] == 5'h01) ? one : '0;
               inc[p*32 + psc_pkg::OFF_TX_MANY_COLL] = (tx_coll_cnt_i[p] > 5'h01) ? one : '0;
            end
         end
      end
   end

   // ****************************************
   // Counter storage
   // ****************************************
   psc_mem #(
      .DEPTH(NENT),
      .WIDTH(32),
      .AW(7)
   ) u_mem (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .rd_addr_i(mem_raddr),
      .rd_data_o(mem_rdata),
      .wr_en_i(mem_we),
      .wr_addr_i(s.cur),
      .wr_data_i(mem_wdata)
   );

   // Stored words keep bit 30 clear; validity is only added on the way out
   assign mem_raddr = s.req ? s.req_idx : s.sweep;
   assign mem_we = s.phase == psc_pkg::PSC_ST_UPDATE;
   assign sum = 31'(mem_rdata[psc_pkg::CNT_W-1:0]) + 31'(s.pend[s.cur]);
   assign ovf = mem_rdata[psc_pkg::OVF_BIT] | sum[30];
   assign mem_wdata = s.svc ? 32'h0000_0000 : {ovf, 1'b0, sum[29:0]};

   // ****************************************
   // Engine and bus
   // ****************************************
   always_comb begin
      logic hit;
      logic [8:0] noff;
      hit = wb_cyc_i && wb_stb_i && !s.ack;
      noff = s.off;
      next_s = s;
      // Events kept unless a read superseded by a newer trigger clears its entry: snapshot taken out, new increments always added
      for (int e = 0; e < NENT; e++) begin
         next_s.pend[e] = ((mem_we && 7'(e) == s.cur) ? PEND_W'(0) : s.pend[e]) + PEND_W'(inc[e]);
      end
      // Drop counters wrap silently
      for (int i = 0; i < psc_pkg::NPORT; i++) begin
         next_s.drop[i] = s.drop[i] + psc_pkg::DROP_W'(tx_drop_i[i]);
         next_s.drop[i + psc_pkg::NPORT] = s.drop[i + psc_pkg::NPORT] + psc_pkg::DROP_W'(rx_drop_i[i]);
      end
      case (s.phase)
         psc_pkg::PSC_ST_FETCH: begin
            next_s.cur = mem_raddr;
            next_s.svc = s.req;
            next_s.req = 1'b0;
            if (!s.req) begin
               next_s.sweep = (s.sweep == 7'(NENT - 1)) ? 7'h00 : s.sweep + 7'h01;
            end
            next_s.phase = psc_pkg::PSC_ST_UPDATE;
         end
         psc_pkg::PSC_ST_UPDATE: begin
            // A newer trigger supersedes this answer
            if (s.svc && !s.req) begin
               next_s.data = {ovf, 1'b1, sum[29:0]};
            end
            next_s.svc = 1'b0;
            next_s.phase = psc_pkg::PSC_ST_FETCH;
         end
         default: begin
            next_s.phase = psc_pkg::PSC_ST_FETCH;
         end
      endcase
      next_s.ack = hit;
      next_s.rdat = 32'h0000_0000;
      if (hit && !wb_we_i) begin
         case (wb_adr_i)
            psc_pkg::REG_CTRL: next_s.rdat = {23'h000000, s.max1536, s.sel};
            psc_pkg::REG_OFFSET: next_s.rdat = {23'h000000, s.off};
            psc_pkg::REG_DATA: next_s.rdat = s.data;
            psc_pkg::REG_STATUS: next_s.rdat = {31'h00000000, s.req | s.svc};
            default: next_s.rdat = 32'h0000_0000;
         endcase
      end
      if (hit && wb_we_i) begin
         case (wb_adr_i)
            psc_pkg::REG_CTRL: begin
               if (wb_sel_i[0]) begin
                  next_s.sel = wb_dat_i[7:0];
               end
               if (wb_sel_i[1]) begin
                  next_s.max1536 = wb_dat_i[psc_pkg::CTRL_MAX1536_BIT];
               end
            end
            psc_pkg::REG_OFFSET: begin
               if (wb_sel_i[1]) begin
                  noff[8] = wb_dat_i[psc_pkg::OFFSET_MSB_BIT];
               end
               if (wb_sel_i[0]) begin
                  noff[7:0] = wb_dat_i[7:0];
                  // Low byte write triggers the read
                  if (s.sel == psc_pkg::SEL_PORT_CNT && noff < psc_pkg::PORT3_BASE + 9'(psc_pkg::NCNT)) begin
                     next_s.req = 1'b1;
                     next_s.req_idx = noff[6:0];
                     next_s.data = 32'h0000_0000;
                  end else if (s.sel == psc_pkg::SEL_DROP_CNT && noff >= psc_pkg::DROP_TX_BASE &&
                               noff <= psc_pkg::DROP_LAST) begin
                     next_s.data = {16'h0000, s.drop[3'(noff - psc_pkg::DROP_TX_BASE)]};
                  end else begin
                     next_s.data = 32'h0000_0000;
                  end
               end
               next_s.off = noff;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign wb_ack_o = s.ack;
   assign wb_dat_o = s.rdat;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Offset write as the engine sees it; bit 8 keeps its old value unless lane 1 is written
   logic off_wr;
   logic [8:0] chk_off;
   assign off_wr = wb_cyc_i && wb_stb_i && !s.ack && wb_we_i &&
      wb_adr_i == psc_pkg::REG_OFFSET && wb_sel_i[0];
   assign chk_off = {wb_sel_i[1] ? wb_dat_i[psc_pkg::OFFSET_MSB_BIT] : s.off[8], wb_dat_i[7:0]};

   sequence trig_port_s;
      off_wr && s.sel == psc_pkg::SEL_PORT_CNT && chk_off < psc_pkg::PORT3_BASE + 9'(psc_pkg::NCNT);
   endsequence

   sequence trig_drop_s;
      off_wr && s.sel == psc_pkg::SEL_DROP_CNT;
   endsequence

   a_valid_low_trig: assert property (trig_port_s |=> !s.data[psc_pkg::VALID_BIT])
      else $error("valid bit not cleared on trigger");
   a_valid_rises: assert property (trig_port_s ##1 (!off_wr) [*3] |=> s.data[psc_pkg::VALID_BIT])
      else $error("counter read never became valid");
   a_clear_on_read: assert property (s.svc && mem_we |=> u_mem.s.word[$past(s.cur)][29:0] == 30'h0)
      else $error("read counter not cleared");
   a_ovf_sticky: assert property (mem_we && !s.svc && mem_rdata[31] |-> mem_wdata[31])
      else $error("overflow flag lost");
   a_drop_inc: assert property (tx_drop_i[0] |=> s.drop[0] == $past(s.drop[0]) + 16'h0001)
      else $error("drop counter did not increment");
   a_drop_no_clear: assert property ((trig_drop_s and !tx_drop_i[1]) |=> s.drop[1] == $past(s.drop[1]))
      else $error("drop counter changed on read");
   a_reserved_zero: assert property (trig_drop_s |=> s.data[30:16] == 15'h0000)
      else $error("reserved bits not zero");
   a_pend_drain: assert property (mem_we && !inc[s.cur][0] && inc[s.cur] == '0 |=> s.pend[$past(s.cur)] == '0)
      else $error("pending amount not drained");
   a_ack_pulse: assert property (s.ack |=> !s.ack)
      else $error("ack held longer than one cycle");

endmodule : psc_top

// ==== bench/test_psc_top.sv ====
// Self-checking bench for the port statistics counters over classic Wishbone.
// Assumes psc_top with its default parameters and a 40 MHz clock.
`timescale 1ns/1ps
module test_psc_top;
   localparam logic [31:0] VAL = 32'h4000_0000;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic [2:0] rx_done_i = 3'h0, rx_crc_ok_i = 3'h0, rx_dribble_i = 3'h0, rx_sym_err_i = 3'h0;
   logic [2:0] rx_hi_prio_i = 3'h0, rx_bcast_i = 3'h0, rx_mcast_i = 3'h0, rx_ctrl_type_i = 3'h0;
   logic [2:0] rx_pause_match_i = 3'h0, tx_done_i = 3'h0, tx_ok_i = 3'h0, tx_hi_prio_i = 3'h0;
   logic [2:0] tx_pause_i = 3'h0, tx_bcast_i = 3'h0, tx_mcast_i = 3'h0, tx_defer_i = 3'h0;
   logic [2:0] tx_excess_i = 3'h0, tx_late_coll_i = 3'h0, tx_drop_i = 3'h0, rx_drop_i = 3'h0;
   logic [2:0][10:0] rx_len_i = '0, tx_len_i = '0;
   logic [2:0][4:0] tx_coll_cnt_i = '0;
   logic max_sz = 1'b0, want_chk = 1'b0;
   int failures = 0, tests_run = 0, seed = 92, cycles = 0;
   string name_q[$];
   logic [31:0] exp_q[$];
   // Receive cases: length, flags {hi,crc,drib,sym,bc,mc,ctl,pm}, offset read
   int el[11] = '{40, 40, 1530, 1530, 100, 100, 100, 64, 64, 100, 100};
   logic [7:0] ef[11] = '{8'h40, 8'h00, 8'h40, 8'h00, 8'h50, 8'h00, 8'h20, 8'h42, 8'h43, 8'h44, 8'h40};
   int eo[11] = '{'h02, 'h03, 'h04, 'h05, 'h06, 'h07, 'h08, 'h09, 'h0a, 'h0c, 'h0d};
   // Transmit cases: flags {ok,hi,pause,bc,mc,defer,excess}, collisions, offset, count (0 = octets)
   logic [6:0] tf[11] = '{7'h40, 7'h40, 7'h40, 7'h01, 7'h42, 7'h50, 7'h48, 7'h44, 7'h40, 7'h40, 7'h60};
   int tc[11] = '{1, 3, 3, 0, 0, 0, 0, 0, 0, 0, 0};
   int to[11] = '{'h1e, 'h1f, 'h1c, 'h1d, 'h1b, 'h17, 'h18, 'h19, 'h1a, 'h14, 'h15};
   int tn[11] = '{1, 1, 3, 1, 1, 1, 1, 1, 1, 0, 0};

   psc_top u_psc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_done_i(rx_done_i), .rx_len_i(rx_len_i),
      .rx_crc_ok_i(rx_crc_ok_i), .rx_dribble_i(rx_dribble_i), .rx_sym_err_i(rx_sym_err_i),
      .rx_hi_prio_i(rx_hi_prio_i), .rx_bcast_i(rx_bcast_i), .rx_mcast_i(rx_mcast_i),
      .rx_ctrl_type_i(rx_ctrl_type_i), .rx_pause_match_i(rx_pause_match_i), .tx_done_i(tx_done_i),
      .tx_len_i(tx_len_i), .tx_ok_i(tx_ok_i), .tx_hi_prio_i(tx_hi_prio_i), .tx_pause_i(tx_pause_i),
      .tx_bcast_i(tx_bcast_i), .tx_mcast_i(tx_mcast_i), .tx_defer_i(tx_defer_i),
      .tx_coll_cnt_i(tx_coll_cnt_i), .tx_excess_i(tx_excess_i), .tx_late_coll_i(tx_late_coll_i),
      .tx_drop_i(tx_drop_i), .rx_drop_i(rx_drop_i));

   // ****************************************
   // Bus and event drivers
   // ****************************************
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   function automatic int rnd(input int n);
      return int'($unsigned($random(seed)) % n);
   endfunction : rnd

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic conclude;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude

   // Request held until the edge that samples ack, then released for a cycle
   task automatic wb(input logic chk, input logic we, input logic [7:0] adr, input logic [31:0] dat,
         input logic [3:0] sel, output logic [31:0] rd);
      want_chk <= chk;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task automatic chk_rd(input string nm, input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] d;
      name_q.push_back(nm);
      exp_q.push_back(exp);
      wb(1'b1, 1'b0, adr, 32'h0, 4'hf, d);
   endtask : chk_rd

   task automatic rd_cnt(input string nm, input int p, input int off, input logic [31:0] exp);
      logic [8:0] ix;
      logic [31:0] d;
      ix = 9'(p * 32 + off);
      d = {23'h0, max_sz, (ix[8] ? psc_pkg::SEL_DROP_CNT : psc_pkg::SEL_PORT_CNT)};
      wb(1'b0, 1'b1, psc_pkg::REG_CTRL, d, 4'h3, d);
      wb(1'b0, 1'b1, psc_pkg::REG_OFFSET, {23'h0, ix}, 4'h3, d);
      d = 32'h0;
      for (int i = 0; i < 8 && !ix[8] && d[30] !== 1'b1; i++) begin
         wb(1'b0, 1'b0, psc_pkg::REG_DATA, 32'h0, 4'hf, d);
      end
      chk_rd(nm, psc_pkg::REG_DATA, exp);
   endtask : rd_cnt

   task automatic rx_frame(input int p, input int len, input logic [7:0] f);
      rx_len_i[p] <= 11'(len);
      {rx_hi_prio_i[p], rx_crc_ok_i[p], rx_dribble_i[p], rx_sym_err_i[p], rx_bcast_i[p], rx_mcast_i[p],
         rx_ctrl_type_i[p], rx_pause_match_i[p]} <= f;
      rx_done_i[p] <= 1'b1;
      @(posedge clk_i);
      rx_done_i <= 3'h0;
      @(posedge clk_i);
   endtask : rx_frame

   task automatic tx_frame(input int p, input int len, input logic [6:0] f, input logic [4:0] coll);
      tx_len_i[p] <= 11'(len);
      {tx_ok_i[p], tx_hi_prio_i[p], tx_pause_i[p], tx_bcast_i[p], tx_mcast_i[p], tx_defer_i[p],
         tx_excess_i[p]} <= f;
      tx_coll_cnt_i[p] <= coll;
      tx_done_i[p] <= 1'b1;
      @(posedge clk_i);
      tx_done_i <= 3'h0;
      @(posedge clk_i);
   endtask : tx_frame

   task automatic reset;
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      max_sz = 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : reset

   // ****************************************
   // Result watcher and run control
   // ****************************************
   always @(posedge clk_i) begin
      if (want_chk && wb_ack_o === 1'b1 && exp_q.size() > 0) begin
         check(name_q.pop_front(), wb_dat_o, exp_q.pop_front());
      end
   end

   // Whole run is under a thousand cycles; the ceiling leaves ample margin
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         conclude();
      end
   end

   initial begin
      logic [31:0] d;
      int p, len, slo, shi;
      @(posedge clk_i);
      reset();
      p = rnd(3);
      wb(1'b0, 1'b1, 8'h10, 32'hffff_ffff, 4'hf, d);
      chk_rd("unmapped", 8'h10, 32'h0);
      chk_rd("status", psc_pkg::REG_STATUS, 32'h0);
      rd_cnt("reset count", p, rnd(32), VAL);
      rd_cnt("beyond ports", 3, 0, 32'h0);
      $display("done: reset values");
      slo = 0;
      shi = 0;
      for (int k = 0; k < 6; k++) begin
         len = (k == 0) ? 64 : (32 << k) + rnd(32 << k);
         len = (k == 5) ? 1024 + rnd(499) : len;
         len = (k == 1) ? 65 + rnd(63) : len;
         rx_frame(p, len, {k[0], 7'h48});
         slo += k[0] ? 0 : len;
         shi += k[0] ? len : 0;
      end
      for (int k = 0; k < 6; k++) begin
         rd_cnt("length bucket", p, 'h0e + k, VAL + 1);
      end
      rd_cnt("rx octets low", p, 'h00, VAL + slo);
      rd_cnt("rx octets high", p, 'h01, VAL + shi);
      rd_cnt("rx broadcast", p, 'h0b, VAL + 6);
      rd_cnt("rx broadcast reread", p, 'h0b, VAL);
      $display("done: length buckets");
      for (int k = 0; k < 11; k++) begin
         reset();
         p = rnd(3);
         rx_frame(p, el[k], ef[k]);
         rd_cnt("rx class", p, eo[k], VAL + 1);
      end
      $display("done: receive classes");
      for (int k = 0; k < 11; k++) begin
         reset();
         p = rnd(3);
         len = 64 + rnd(1459);
         tx_frame(p, len, tf[k], 5'(tc[k]));
         rd_cnt("tx class", p, to[k], VAL + ((tn[k] == 0) ? len : tn[k]));
      end
      tx_late_coll_i[p] <= 1'b1;
      @(posedge clk_i);
      tx_late_coll_i <= 3'h0;
      @(posedge clk_i);
      rd_cnt("late collision", p, 'h16, VAL + 1);
      $display("done: transmit classes");
      reset();
      max_sz = 1'b1;
      wb(1'b0, 1'b1, psc_pkg::REG_CTRL, {23'h0, 1'b1, psc_pkg::SEL_PORT_CNT}, 4'h3, d);
      rx_frame(p, 1530, 8'h40);
      rd_cnt("long limit bucket", p, 'h13, VAL + 1);
      rd_cnt("long limit oversize", p, 'h04, VAL);
      $display("done: frame size setting");
      reset();
      for (int k = 0; k < 2; k++) begin
         tx_drop_i[p] <= 1'b1;
         rx_drop_i[p] <= k[0];
         @(posedge clk_i);
         tx_drop_i <= 3'h0;
         rx_drop_i <= 3'h0;
         @(posedge clk_i);
      end
      rd_cnt("tx drop", 8, p, 32'h2);
      rd_cnt("rx drop", 8, 3 + p, 32'h1);
      rd_cnt("tx drop reread", 8, p, 32'h2);
      $display("done: drop counters");
      conclude();
   end
endmodule : test_psc_top
